// ===== hw/compact_timer.sv
// Compact ten-bit timer with AXI4-Lite register access
//
// Overview of operation
// RULE1: Ten-bit up counter advances on timer ticks
// RULE2: P checks top three bits, A all
// RULE3: Counter clears when timer_on rises and on its clear match
// RULE4: Pause holds count, resumes from there
// RULE5: Clock select picks one of seven sources; codes 4 and 5 both pick sub_clk_tick
// RULE6: Off stops counter, value kept
// RULE7: Switch-on restores initial output level
// RULE8: P period is value times 128, zero 1024
// RULE9: Select zero: clear on P match, overflow
// RULE10: Select one: clear on A match
// RULE11: PWM clear source follows role swap
// RULE12: Mode select picks compare, PWM or timer
// RULE13: Software stops timer before mode change
// RULE14: Compare mode: A match does pin action
// RULE15: PWM pin action forces inactive, active, wave
// RULE16: Software changes PWM pin action only off
// RULE17: Initial level sets start or active level
// RULE18: Drive equal to level gives no change
// RULE19: Invert bit flips output outside timer mode
// RULE20: Role swap exchanges period and duty
// RULE21: Clearing match or overflow raises request
// RULE22: A low write buffered, copied on high
// RULE23: High read captures low byte in buffer
// RULE24: Second pin is inverse of first
// RULE25: Separate requests for A and P matches
// RULE26: PWM active from clear until duty value
// RULE27: P match needs low seven bits zero
`timescale 1ns/100ps
`default_nettype none
`include "compact_timer_params.svh"
module compact_timer
  import compact_timer_pkg::*;
(
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic [11:0] s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [11:0] s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  input  wire logic        high_clk_tick,
  input  wire logic        sub_clk_tick,
  input  wire logic        ext_clock_pin,
  output logic             timer_output_pin,
  output logic             timer_output_pin_inverted,
  output logic             match_a_irq,
  output logic             match_p_irq
);
  // ---------------------------------------------------------------
  // Register state
  // ---------------------------------------------------------------
  logic [7:0]  ctrl0_q;
  logic [7:0]  ctrl1_q;
  logic [9:0]  cmpa_q;
  logic [7:0]  wbuf_q;
  logic [7:0]  rbuf_q;
  logic        on_prev_q;
  logic        out_q;
  logic        pwm_q;
  logic        flag_a_q;
  logic        flag_p_q;
  logic        irq_a_q;
  logic        irq_p_q;
  logic        aw_held_q;
  logic [11:0] aw_addr_q;
  logic        w_held_q;
  logic [31:0] w_data_q;
  logic [3:0]  w_strb_q;
  logic        bvalid_q;
  logic        rvalid_q;
  logic [31:0] rdata_q;

  // ---------------------------------------------------------------
  // Field decode
  // ---------------------------------------------------------------
  logic        timer_on;
  logic        pause_ctl;
  logic [2:0]  clock_select;
  logic [2:0]  compare_p_value;
  timer_mode_t mode_select;
  pin_action_t pin_action_select;
  logic        output_initial_level;
  logic        output_invert;
  logic        pwm_role_swap;
  logic        clear_source_select;
  logic        start_w;
  logic        run_w;
  logic        pwm_mode_w;
  logic        tick_w;
  logic        match_a_w;
  logic        match_p_w;
  logic [9:0]  count_w;

  assign timer_on             = ctrl0_q[`CT_C0_ON];
  assign pause_ctl            = ctrl0_q[`CT_C0_PAUSE];
  assign clock_select         = ctrl0_q[`CT_C0_CKSEL_HI:`CT_C0_CKSEL_LO];
  assign compare_p_value      = ctrl0_q[`CT_C0_PER_HI:0];
  assign mode_select          =
    timer_mode_t'(ctrl1_q[`CT_C1_MODE_HI:`CT_C1_MODE_LO]); // see RULE12
  assign pin_action_select    =
    pin_action_t'(ctrl1_q[`CT_C1_PIN_HI:`CT_C1_PIN_LO]);
  assign output_initial_level = ctrl1_q[`CT_C1_INIT];
  assign output_invert        = ctrl1_q[`CT_C1_INV];
  assign pwm_role_swap        = ctrl1_q[`CT_C1_SWAP];
  assign clear_source_select  = ctrl1_q[`CT_C1_CLRSEL];
  assign start_w    = timer_on && !on_prev_q;
  assign run_w      = timer_on && !pause_ctl && !start_w;
  assign pwm_mode_w = (mode_select == MODE_PWM);

  // ---------------------------------------------------------------
  // Tick source and counter core
  // ---------------------------------------------------------------
  compact_timer_tick u_tick (
    .aclk          (aclk),
    .aresetn       (aresetn),
    .clock_select  (clock_select),
    .high_clk_tick (high_clk_tick),
    .sub_clk_tick  (sub_clk_tick),
    .ext_clock_pin (ext_clock_pin),
    .tick          (tick_w)
  );

  compact_timer_core u_core (
    .aclk                (aclk),
    .aresetn             (aresetn),
    .tick                (tick_w),
    .run                 (run_w),
    .start               (start_w),
    .pwm_mode            (pwm_mode_w),
    .clear_source_select (clear_source_select),
    .pwm_role_swap       (pwm_role_swap),
    .compare_p_value     (compare_p_value),
    .compare_a_value     (cmpa_q),
    .count               (count_w),
    .match_a             (match_a_w),
    .match_p             (match_p_w)
  );

  // ---------------------------------------------------------------
  // Output pin logic
  // ---------------------------------------------------------------
  logic [10:0] p_period_w;
  logic [10:0] duty_w;
  logic [10:0] period_w;
  logic        duty_hit_w;
  logic        pwm_active_w;
  logic        out_cmp_d;
  logic        p_clear_w;
  logic        pin_level_w;

  // Duty edge from the comparator that does not set the period
  assign p_period_w = (compare_p_value == 3'h0) ? `CT_FULL_PERIOD
                    : 11'(compare_p_value) * `CT_P_STEP; // see RULE8
  assign duty_w     = pwm_role_swap ? p_period_w
                                    : {1'b0, cmpa_q}; // see RULE20
  assign period_w   = pwm_role_swap ? {1'b0, cmpa_q} : p_period_w;
  assign duty_hit_w = tick_w && run_w
                   && ({1'b0, count_w} + 11'h001 == duty_w)
                   && (duty_w < period_w); // see RULE26
  assign p_clear_w  = !pwm_role_swap && (match_p_w
                   || (tick_w && run_w && count_w == 10'h3FF));

  // Compare mode pin action on each A match
  always_comb begin
    out_cmp_d = out_q;
    if (match_a_w) begin
      case (pin_action_select) // see RULE14 see RULE18
        PIN_KEEP:   out_cmp_d = out_q;
        PIN_LOW:    out_cmp_d = 1'b0;
        PIN_HIGH:   out_cmp_d = 1'b1;
        PIN_TOGGLE: out_cmp_d = !out_q;
        default:    out_cmp_d = out_q;
      endcase
    end
  end

  // PWM phase: active after period clear, inactive after duty match
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pwm_q <= 1'b1;
    end else if (start_w) begin
      pwm_q <= 1'b1;
    end else if ((pwm_role_swap && match_a_w) || p_clear_w) begin
      pwm_q <= 1'b1; // see RULE26
    end else if (duty_hit_w) begin
      pwm_q <= 1'b0;
    end
  end

  // Compare mode level, restored to initial on switch-on
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      out_q <= 1'b0;
    end else if (start_w) begin
      out_q <= output_initial_level; // see RULE7 see RULE17
    end else if (mode_select == MODE_COMPARE) begin
      out_q <= out_cmp_d;
    end
  end

  assign pwm_active_w = (pin_action_select == PIN_LOW)
                     || (pin_action_select == PIN_HIGH && pwm_q);
  // PWM output with polarity: active level or its inverse, then the invert bit
  always_comb begin
    case (mode_select)
      MODE_COMPARE: pin_level_w = out_q ^ output_invert; // see RULE19
      MODE_PWM:     pin_level_w = (pwm_active_w ? output_initial_level
                                  : !output_initial_level)
                                  ^ output_invert; // see RULE15
      default:      pin_level_w = 1'b0;
    endcase
  end

  assign timer_output_pin          = pin_level_w;
  assign timer_output_pin_inverted = !pin_level_w; // see RULE24

  // ---------------------------------------------------------------
  // Match flags and interrupt requests
  // ---------------------------------------------------------------
  logic        flag_p_ev_w;
  logic        ovf_ev_w;

  // P flag when P can clear or in PWM mode; overflow counts with the P flag
  assign ovf_ev_w    = tick_w && run_w && count_w == 10'h3FF;
  assign flag_p_ev_w = (pwm_mode_w || !clear_source_select)
                     && (match_p_w || ovf_ev_w);
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      irq_a_q <= 1'b0;
      irq_p_q <= 1'b0;
    end else begin
      irq_a_q <= match_a_w; // see RULE21 see RULE25
      irq_p_q <= flag_p_ev_w;
    end
  end
  assign match_a_irq = irq_a_q;
  assign match_p_irq = irq_p_q;

  // ---------------------------------------------------------------
  // AXI4-Lite slave
  // ---------------------------------------------------------------
  logic        wr_go_w;
  logic [11:0] wr_addr_w;
  logic [31:0] wr_data_w;
  logic        wr_lane0_w;
  logic        rd_go_w;
  logic [31:0] rd_val_w;
  logic        status_clr_w;

  assign s_axi_awready = !aw_held_q && !bvalid_q;
  assign s_axi_wready  = !w_held_q && !bvalid_q;
  assign wr_addr_w  = aw_held_q ? aw_addr_q : s_axi_awaddr;
  assign wr_data_w  = w_held_q ? w_data_q : s_axi_wdata;
  assign wr_lane0_w = w_held_q ? w_strb_q[0] : s_axi_wstrb[0];
  assign wr_go_w    = !bvalid_q
                   && (aw_held_q || s_axi_awvalid)
                   && (w_held_q || s_axi_wvalid) && wr_lane0_w;
  assign s_axi_bvalid  = bvalid_q;
  assign s_axi_bresp   = 2'h0;
  assign s_axi_arready = !rvalid_q;
  assign rd_go_w       = s_axi_arvalid && !rvalid_q;
  assign s_axi_rvalid  = rvalid_q;
  assign s_axi_rdata   = rdata_q;
  assign s_axi_rresp   = 2'h0;
  assign status_clr_w  = rd_go_w && s_axi_araddr == `CT_OFS_STATUS;

  // Write channel capture and response
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held_q <= 1'b0;
      aw_addr_q <= 12'h000;
      w_held_q  <= 1'b0;
      w_data_q  <= 32'h0000_0000;
      w_strb_q  <= 4'h0;
      bvalid_q  <= 1'b0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_held_q <= 1'b1;
        aw_addr_q <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_held_q <= 1'b1;
        w_data_q <= s_axi_wdata;
        w_strb_q <= s_axi_wstrb;
      end
      if (!bvalid_q && (aw_held_q || s_axi_awvalid)
          && (w_held_q || s_axi_wvalid)) begin
        bvalid_q  <= 1'b1;
        aw_held_q <= 1'b0;
        w_held_q  <= 1'b0;
      end else if (bvalid_q && s_axi_bready) begin
        bvalid_q <= 1'b0;
      end
    end
  end

  // Register writes; the counter pair is read only
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl0_q   <= `CT_CTRL_RESET;
      ctrl1_q   <= `CT_CTRL_RESET;
      cmpa_q    <= 10'h000;
      wbuf_q    <= 8'h00;
      on_prev_q <= 1'b0;
    end else begin
      on_prev_q <= timer_on;
      if (wr_go_w) begin
        case (wr_addr_w)
          `CT_OFS_CTRL0:   ctrl0_q <= wr_data_w[7:0];
          `CT_OFS_CTRL1:   ctrl1_q <= wr_data_w[7:0];
          `CT_OFS_CMPA_LO: wbuf_q  <= wr_data_w[7:0]; // see RULE22
          `CT_OFS_CMPA_HI: cmpa_q  <= {wr_data_w[1:0], wbuf_q};
          default:         ctrl0_q <= ctrl0_q;
        endcase
      end
    end
  end

  // Read mux; high byte reads latch the low byte
  always_comb begin
    case (s_axi_araddr)
      `CT_OFS_CTRL0:   rd_val_w = {24'h000000, ctrl0_q};
      `CT_OFS_CTRL1:   rd_val_w = {24'h000000, ctrl1_q};
      `CT_OFS_CNT_LO:  rd_val_w = {24'h000000, rbuf_q}; // see RULE23
      `CT_OFS_CNT_HI:  rd_val_w = {30'h00000000, count_w[9:8]};
      `CT_OFS_CMPA_LO: rd_val_w = {24'h000000, rbuf_q};
      `CT_OFS_CMPA_HI: rd_val_w = {30'h00000000, cmpa_q[9:8]};
      `CT_OFS_STATUS:  rd_val_w = {30'h00000000, flag_p_q, flag_a_q};
      default:         rd_val_w = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid_q <= 1'b0;
      rdata_q  <= 32'h0000_0000;
      rbuf_q   <= 8'h00;
    end else begin
      if (rd_go_w) begin
        rvalid_q <= 1'b1;
        rdata_q  <= rd_val_w;
        if (s_axi_araddr == `CT_OFS_CNT_HI) begin
          rbuf_q <= count_w[7:0]; // see RULE23
        end else if (s_axi_araddr == `CT_OFS_CMPA_HI) begin
          rbuf_q <= cmpa_q[7:0];
        end
      end else if (rvalid_q && s_axi_rready) begin
        rvalid_q <= 1'b0;
      end
    end
  end

  // Sticky match flags, cleared by reading status; set wins
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      flag_a_q <= 1'b0;
      flag_p_q <= 1'b0;
    end else begin
      flag_a_q <= match_a_w || (flag_a_q && !status_clr_w);
      flag_p_q <= flag_p_ev_w || (flag_p_q && !status_clr_w);
    end
  end
endmodule : compact_timer
`default_nettype wire

// ===== hw/compact_timer_params.svh
// Register offsets, field positions, reset values and timing counts
`ifndef COMPACT_TIMER_PARAMS_SVH
`define COMPACT_TIMER_PARAMS_SVH
`define CT_OFS_CTRL0      12'h000
`define CT_OFS_CTRL1      12'h004
`define CT_OFS_CNT_LO     12'h008
`define CT_OFS_CNT_HI     12'h00C
`define CT_OFS_CMPA_LO    12'h010
`define CT_OFS_CMPA_HI    12'h014
`define CT_OFS_STATUS     12'h018
`define CT_C0_PAUSE       7
`define CT_C0_CKSEL_HI    6
`define CT_C0_CKSEL_LO    4
`define CT_C0_ON          3
`define CT_C0_PER_HI      2
`define CT_C1_MODE_HI     7
`define CT_C1_MODE_LO     6
`define CT_C1_PIN_HI      5
`define CT_C1_PIN_LO      4
`define CT_C1_INIT        3
`define CT_C1_INV         2
`define CT_C1_SWAP        1
`define CT_C1_CLRSEL      0
`define CT_CTRL_RESET     8'h00
`define CT_SYS_DIV        3'h3
`define CT_HIGH_DIV16     6'h0F
`define CT_HIGH_DIV64     6'h3F
`define CT_P_STEP         11'h080
`define CT_FULL_PERIOD    11'h400
`endif

// ===== hw/compact_timer_pkg.sv
// Types shared by the compact timer files
package compact_timer_pkg;
  typedef enum logic [1:0] {
    MODE_COMPARE,
    MODE_UNDEF,
    MODE_PWM,
    MODE_TIMER
  } timer_mode_t;
  typedef enum logic [1:0] {
    PIN_KEEP,
    PIN_LOW,
    PIN_HIGH,
    PIN_TOGGLE
  } pin_action_t;
endpackage : compact_timer_pkg

// ===== hw/compact_timer_tick.sv
// Count tick generator: clock source selection and external pin edges
`timescale 1ns/100ps
`default_nettype none
`include "compact_timer_params.svh"
module compact_timer_tick (
  input  wire logic       aclk,
  input  wire logic       aresetn,
  input  wire logic [2:0] clock_select,
  input  wire logic       high_clk_tick,
  input  wire logic       sub_clk_tick,
  input  wire logic       ext_clock_pin,
  output logic            tick
);
  logic [1:0] sys_div_q;
  logic [5:0] high_div_q;
  logic [2:0] ext_sync_q;
  logic       div4_w;
  logic       div16_w;
  logic       div64_w;
  logic       ext_rise_w;
  logic       ext_fall_w;

  // Dividers and pin synchroniser; bit 0 is read only by bit 1
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sys_div_q  <= 2'h0;
      high_div_q <= 6'h00;
      ext_sync_q <= 3'h0;
    end else begin
      sys_div_q  <= sys_div_q + 2'h1;
      if (high_clk_tick) begin
        high_div_q <= high_div_q + 6'h01;
      end
      ext_sync_q <= {ext_sync_q[1:0], ext_clock_pin};
    end
  end

  assign div4_w     = (sys_div_q == 2'(`CT_SYS_DIV));
  assign div16_w    = high_clk_tick && (high_div_q[3:0] == 4'(`CT_HIGH_DIV16));
  assign div64_w    = high_clk_tick && (high_div_q == 6'(`CT_HIGH_DIV64));
  assign ext_rise_w = ext_sync_q[1] && !ext_sync_q[2];
  assign ext_fall_w = !ext_sync_q[1] && ext_sync_q[2];

  // Source multiplexer
  always_comb begin
    case (clock_select)
      3'h0: tick = div4_w; // see RULE5
      3'h1: tick = 1'b1;
      3'h2: tick = div16_w;
      3'h3: tick = div64_w;
      3'h4: tick = sub_clk_tick;
      3'h5: tick = sub_clk_tick;
      3'h6: tick = ext_rise_w;
      3'h7: tick = ext_fall_w;
      default: tick = 1'b0;
    endcase
  end
endmodule : compact_timer_tick
`default_nettype wire

// ===== hw/compact_timer_core.sv
// Ten-bit counter, both comparators and counter clear logic
`timescale 1ns/100ps
`default_nettype none
`include "compact_timer_params.svh"
module compact_timer_core
  import compact_timer_pkg::*;
(
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic        tick,
  input  wire logic        run,
  input  wire logic        start,
  input  wire logic        pwm_mode,
  input  wire logic        clear_source_select,
  input  wire logic        pwm_role_swap,
  input  wire logic [2:0]  compare_p_value,
  input  wire logic [9:0]  compare_a_value,
  output logic [9:0]       count,
  output logic             match_a,
  output logic             match_p
);
  logic [9:0] count_q;
  logic       ovf_w;
  logic       clear_w;
  logic       clr_by_a_w;

  // Comparators act on the tick that makes the count reach the value
  assign match_p = tick && run && (compare_p_value != 3'h0)
                 && (count_q[9:7] == compare_p_value - 3'h1)
                 && (count_q[6:0] == 7'h7F); // see RULE2 see RULE27
  assign match_a = tick && run
                 && (count_q + 10'h001 == compare_a_value); // see RULE2
  assign ovf_w   = tick && run && (count_q == 10'h3FF);
  // PWM uses the role swap bit; other modes the clear select bit
  assign clr_by_a_w = pwm_mode ? pwm_role_swap
                               : clear_source_select; // see RULE11
  assign clear_w = clr_by_a_w ? match_a
                              : (match_p || ovf_w); // see RULE9 see RULE10
  assign count   = count_q;

  // Counter: cleared on switch-on, held when off or paused
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      count_q <= 10'h000;
    end else if (start) begin
      count_q <= 10'h000; // see RULE3
    end else if (tick && run) begin // see RULE4 see RULE6
      count_q <= clear_w ? 10'h000 : count_q + 10'h001; // see RULE1 see RULE8
    end
  end
endmodule : compact_timer_core
`default_nettype wire

// ===== tb/compact_timer_props.sv
// Checker of compact timer pins and requests
`timescale 1ns/100ps
`default_nettype none
`include "compact_timer_params.svh"
module compact_timer_props
  import compact_timer_pkg::*;
(
  input wire logic        aclk,
  input wire logic        aresetn,
  input wire logic [11:0] s_axi_awaddr,
  input wire logic        s_axi_awvalid,
  input wire logic        s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic        s_axi_wvalid,
  input wire logic        s_axi_wready,
  input wire logic        timer_output_pin,
  input wire logic        timer_output_pin_inverted,
  input wire logic        match_a_irq,
  input wire logic        match_p_irq
);
  logic [7:0]  c0_q;
  logic [7:0]  c1_q;
  logic        wr_w;
  logic        on_w;
  logic        lvl_w;
  timer_mode_t mode_w;
  // ----
  // Shadow control registers
  // ----
  assign wr_w   = s_axi_awvalid && s_axi_awready
                  && s_axi_wvalid && s_axi_wready;
  assign on_w   = c0_q[3];
  assign mode_w = timer_mode_t'(c1_q[7:6]);
  assign lvl_w  = (c1_q[4] ~^ c1_q[3]) ^ c1_q[2];
  // Copy each control write whose address and data are accepted in the same cycle
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      c0_q <= 8'h00;
      c1_q <= 8'h00;
    end else if (wr_w) begin
      if (s_axi_awaddr == `CT_OFS_CTRL0) c0_q <= s_axi_wdata[7:0];
      if (s_axi_awaddr == `CT_OFS_CTRL1) c1_q <= s_axi_wdata[7:0];
    end
  end
  // ----
  // Properties
  // ----
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  sequence s_quiet;
    !match_a_irq && !match_p_irq;
  endsequence
  sequence s_on_rise;
    $rose(on_w) && mode_w == MODE_COMPARE;
  endsequence
  property p_inv; timer_output_pin_inverted == !timer_output_pin; endproperty
  a_inv: assert property (p_inv)
    else $error("Second pin not inverse");
  property p_p_gap; match_p_irq |=> (!match_p_irq) [*8]; endproperty
  a_p_gap: assert property (p_p_gap)
    else $error("P requests too close");
  property p_off; (!on_w) [*3] |-> s_quiet; endproperty
  a_off: assert property (p_off)
    else $error("Request while switched off");
  property p_pause; (c0_q[7]) [*3] |-> s_quiet; endproperty
  a_pause: assert property (p_pause)
    else $error("Request while paused");
  property p_a_clr; (mode_w == MODE_COMPARE && c1_q[0]) [*3] |-> !match_p_irq;
  endproperty
  a_a_clr: assert property (p_a_clr)
    else $error("P request with A clear");
  property p_tmr; $stable(mode_w) && mode_w == MODE_TIMER |-> !timer_output_pin;
  endproperty
  a_tmr: assert property (p_tmr)
    else $error("Pin not low in timer mode");
  property p_force;
    on_w && $past(on_w, 2) && $stable(c1_q) && mode_w == MODE_PWM
      && !c1_q[5] |-> timer_output_pin == lvl_w;
  endproperty
  a_force: assert property (p_force)
    else $error("Forced PWM level wrong");
  property p_init; s_on_rise |=> timer_output_pin == (c1_q[3] ^ c1_q[2]);
  endproperty
  a_init: assert property (p_init)
    else $error("Pin not at initial level");
endmodule : compact_timer_props
bind compact_timer compact_timer_props u_props (.*);
`default_nettype wire

// ===== tb/compact_timer_bench.sv
// Self-checking bench of the compact timer
`timescale 1ns/100ps
`default_nettype none
`include "compact_timer_params.svh"
`define CHK(n, e, g) begin samples_checked++; if ((g) !== (e)) begin \
  n_errors++; $display("BAD %s exp %0h got %0h", n, e, g); end end
module compact_timer_bench;
  logic        aclk = 1'b0, aresetn = 1'b0;
  logic [11:0] s_axi_awaddr = 12'h000;
  logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic [31:0] s_axi_wdata = 32'h0000_0000;
  logic [3:0]  s_axi_wstrb = 4'hF;
  logic [11:0] s_axi_araddr = 12'h000;
  logic        s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic        high_clk_tick = 1'b0, sub_clk_tick = 1'b0, ext_clock_pin = 1'b0;
  logic        s_axi_awready, s_axi_wready, s_axi_bvalid;
  logic        s_axi_arready, s_axi_rvalid;
  logic [1:0]  s_axi_bresp, s_axi_rresp;
  logic [31:0] s_axi_rdata;
  logic        timer_output_pin, timer_output_pin_inverted;
  logic        match_a_irq, match_p_irq;
  logic [7:0]  cc = 8'h00;
  int          n_errors = 0;
  int          samples_checked = 0;
  // ----
  // Clock, side ticks and device
  // ----
  initial begin
    forever #12.5 aclk = ~aclk;
  end
  // High ticks every 2nd cycle, sub ticks every 8th, pin period 8
  always @(posedge aclk) begin
    cc <= cc + 8'h01;
    high_clk_tick <= cc[0];
    sub_clk_tick <= (cc[2:0] == 3'h0);
    ext_clock_pin <= cc[2];
  end
  compact_timer dut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
    .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
    .high_clk_tick, .sub_clk_tick, .ext_clock_pin, .timer_output_pin,
    .timer_output_pin_inverted, .match_a_irq, .match_p_irq);
  // ----
  // Bus and wait helpers
  // ----
  task automatic summarize;
    $display("checks %0d errors %0d", samples_checked, n_errors);
    if (n_errors == 0 && samples_checked > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : summarize
  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    logic aw, w, b = 1'b0;
    int n = 0;
    s_axi_awaddr <= a;
    s_axi_wdata <= {24'h000000, d};
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    while (!b && n < 40) begin
      @(negedge aclk);
      aw = s_axi_awready;
      w = s_axi_wready;
      b = s_axi_bvalid;
      if (b) `CHK("bresp", 2'h0, s_axi_bresp)
      @(posedge aclk);
      if (aw) s_axi_awvalid <= 1'b0;
      if (w) s_axi_wvalid <= 1'b0;
      n++;
    end
    s_axi_bready <= 1'b0;
    if (!b) begin n_errors++; summarize(); end
  endtask : wr
  task automatic rd(input logic [11:0] a, output logic [7:0] d);
    logic ar, r = 1'b0;
    int n = 0;
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    while (!r && n < 40) begin
      @(negedge aclk);
      ar = s_axi_arready;
      r = s_axi_rvalid;
      if (r) `CHK("rresp", 2'h0, s_axi_rresp)
      d = s_axi_rdata[7:0];
      @(posedge aclk);
      if (ar) s_axi_arvalid <= 1'b0;
      n++;
    end
    s_axi_rready <= 1'b0;
    if (!r) begin n_errors++; summarize(); end
  endtask : rd
  task automatic rd_cnt(output logic [9:0] c);
    logic [7:0] h, l;
    rd(`CT_OFS_CNT_HI, h);
    rd(`CT_OFS_CNT_LO, l);
    c = {h[1:0], l};
  endtask : rd_cnt
  task automatic pin(input logic e);
    @(negedge aclk);
    `CHK("pin", e, timer_output_pin)
    @(posedge aclk);
  endtask : pin
  // Wait for a request; count cycles and high pin cycles
  task automatic ev(input logic use_p, output int cyc, output int hi);
    logic e = 1'b0;
    cyc = 0;
    hi = 0;
    while (e !== 1'b1 && cyc < 1500) begin
      @(negedge aclk);
      e = use_p ? match_p_irq : match_a_irq;
      hi += (timer_output_pin === 1'b1);
      cyc++;
      @(posedge aclk);
    end
    if (e !== 1'b1) begin n_errors++; summarize(); end
  endtask : ev
  // ----
  // Scenarios
  // ----
  task automatic t_regs;
    logic [7:0] d;
    wr(`CT_OFS_CNT_LO, 8'h5A);
    for (int i = 0; i < 8; i++) begin
      rd(12'(4 * i), d);
      `CHK("reset", 8'h00, d)
    end
    wr(`CT_OFS_CTRL1, 8'hC0);
    pin(1'b0);
    wr(`CT_OFS_CMPA_LO, 8'hAB);
    rd(`CT_OFS_CMPA_HI, d);
    rd(`CT_OFS_CMPA_LO, d);
    `CHK("low early", 8'h00, d)
    wr(`CT_OFS_CMPA_HI, 8'h02);
    rd(`CT_OFS_CMPA_HI, d);
    `CHK("cmp high", 8'h02, d)
    rd(`CT_OFS_CMPA_LO, d);
    `CHK("cmp low", 8'hAB, d)
  endtask : t_regs
  // Rate of each source, then pause and stop
  task automatic t_clk;
    int exp [8] = '{128, 512, 16, 4, 64, 64, 64, 64};
    logic [9:0] c0, c1;
    wr(`CT_OFS_CTRL1, 8'h00);
    for (int s = 0; s < 8; s++) begin
      wr(`CT_OFS_CTRL0, {1'b0, s[2:0], 4'h8});
      repeat (512) @(posedge aclk);
      wr(`CT_OFS_CTRL0, {1'b1, s[2:0], 4'h8});
      rd_cnt(c0);
      `CHK("rate", 1'b1, c0 + 4 >= exp[s] && c0 <= exp[s] + 4)
      repeat (20) @(posedge aclk);
      rd_cnt(c1);
      `CHK("paused", c0, c1)
      wr(`CT_OFS_CTRL0, {1'b0, s[2:0], 4'h0});
      rd_cnt(c0);
      repeat (20) @(posedge aclk);
      rd_cnt(c1);
      `CHK("stopped", c0, c1)
    end
  endtask : t_clk
  task automatic t_cmp;
    logic [1:0] act;
    logic init, inv, lvl;
    int c, h;
    wr(`CT_OFS_CMPA_LO, 8'h64);
    wr(`CT_OFS_CMPA_HI, 8'h00);
    for (int i = 0; i < 16; i++) begin
      {inv, init, act} = i[3:0];
      lvl = act == 2'h0 ? init : act == 2'h3 ? !init : act[1];
      wr(`CT_OFS_CTRL0, 8'h10);
      wr(`CT_OFS_CTRL1, {2'b00, act, init, inv, 2'b01});
      wr(`CT_OFS_CTRL0, 8'h18);
      repeat (2) @(posedge aclk);
      pin(init ^ inv);
      ev(1'b0, c, h);
      pin(lvl ^ inv);
      ev(1'b0, c, h);
      `CHK("A period", 100 - 1, c)
      pin((act == 2'h3 ? init : lvl) ^ inv);
    end
  endtask : t_cmp
  task automatic t_pwm;
    logic [9:0] ca [4] = '{10'h020, 10'h0C8, 10'h12C, 10'h020};
    logic [7:0] cf [4] = '{8'hA9, 8'hAA, 8'hA8, 8'hAC};
    int per [4] = '{128, 200, 128, 128};
    int act [4] = '{32, 128, 128, 96};
    int c, h;
    for (int f = 0; f < 2; f++) begin
      wr(`CT_OFS_CTRL0, 8'h10);
      wr(`CT_OFS_CTRL1, {3'b100, f[0], 4'h8});
      wr(`CT_OFS_CTRL0, 8'h19);
      repeat (2) @(posedge aclk);
      pin(f[0]);
    end
    for (int k = 0; k < 4; k++) begin
      wr(`CT_OFS_CTRL0, 8'h10);
      wr(`CT_OFS_CMPA_LO, ca[k][7:0]);
      wr(`CT_OFS_CMPA_HI, {6'h00, ca[k][9:8]});
      wr(`CT_OFS_CTRL1, cf[k]);
      wr(`CT_OFS_CTRL0, 8'h19);
      ev(!cf[k][1], c, h);
      ev(!cf[k][1], c, h);
      `CHK("PWM period", per[k], c)
      `CHK("PWM active", act[k], h)
    end
  endtask : t_pwm
  initial begin
    repeat (10) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    t_regs();
    t_clk();
    t_cmp();
    t_pwm();
    summarize();
  end
endmodule : compact_timer_bench
`default_nettype wire
